// ===== hw/srpm_pair_swap.sv
// Twisted-pair role swap: routes transmit and receive onto the pin pairs.
// Assumes the analog front end honours the per-pair drive enables.
`timescale 1ns/1ps
module srpm_pair_swap (
  input  wire logic swap_in,
  input  wire logic tx_pos_in,
  input  wire logic tx_neg_in,
  input  wire logic out_pos_in,
  input  wire logic out_neg_in,
  input  wire logic in_pos_in,
  input  wire logic in_neg_in,
  output logic      out_pos_out,
  output logic      out_neg_out,
  output logic      out_oe_out,
  output logic      in_pos_out,
  output logic      in_neg_out,
  output logic      in_oe_out,
  output logic      rx_pos_out,
  output logic      rx_neg_out
);

  // ********************************************************************
  // Routing
  // ********************************************************************
  always_comb begin
    out_pos_out = swap_in ? 1'h0 : tx_pos_in;
    out_neg_out = swap_in ? 1'h0 : tx_neg_in;
    out_oe_out  = !swap_in;
    in_pos_out  = swap_in ? tx_pos_in : 1'h0;
    in_neg_out  = swap_in ? tx_neg_in : 1'h0;
    in_oe_out   = swap_in;
    rx_pos_out  = swap_in ? out_pos_in : in_pos_in;
    rx_neg_out  = swap_in ? out_neg_in : in_neg_in;
  end

endmodule : srpm_pair_swap

// ===== hw/srpm_sync.sv
// Three-stage synchroniser with agreement filter for one pin input.
// Assumes the pin is asynchronous to clk_in.
`timescale 1ns/1ps
module srpm_sync (
  input  wire logic clk_in,
  input  wire logic rst_n_in,
  input  wire logic pin_in,
  output logic      level_out
);

  typedef struct packed {
    logic [srpm_pkg::SRPM_SYNC_STAGES-1:0] stg;
    logic                                  lvl;
  } srpm_sync_t;

  srpm_sync_t s_r;
  srpm_sync_t s_nxt;

  // ********************************************************************
  // Filter
  // ********************************************************************
  // Only the second and third stages are compared; the first is never looked at
  always_comb begin
    s_nxt     = s_r;
    s_nxt.stg = {s_r.stg[1:0], pin_in};
    if (!rst_n_in) begin
      // Straps sit still under reset; taking the second stage has the level ready at release
      s_nxt.lvl = s_r.stg[1];
    end else if (s_r.stg[1] == s_r.stg[2]) begin
      s_nxt.lvl = s_r.stg[2];
    end
  end

  // No clearing under reset: the stages must keep tracking the strap pins
  always_ff @(posedge clk_in) begin
    s_r <= s_nxt;
  end

  assign level_out = s_r.lvl;

endmodule : srpm_sync

// ===== hw/srpm_top.sv
// Strap latching and serial ROM pin multiplexing for the Ethernet controller.
// Assumes strap resistors hold the shared pins while reset is low, and that
// MII monitor and crossover inputs come from logic on clk_in.
// How it works
// - A low speed strap gives 10 Mbps half duplex without auto-negotiation, a high one 100 Mbps half duplex with it.
// - The bus width strap is read from the ROM data pin in the cycle reset is released.
// - A latched high bus width strap selects a 32-bit host bus, a low one a 16-bit bus.
// - In ROM role the data pin is bidirectional, driven for writes and read back for ROM data.
// - The data pin can instead carry a general output or a monitor of transmit enable or transmit clock.
// - Whenever the data pin is not in ROM role the ROM chip select is held inactive.
// - The clock pin can instead carry a general output or a monitor of receive valid or receive clock.
// - Whenever the clock pin is not in ROM role the ROM chip select is held inactive.
// - In general output role neither pin is read as an input except the data pin for the width strap at reset release.
// - A detected or manually chosen reversed cable swaps the roles of the transmit and receive pairs.
// - The speed strap is latched at reset release and only sets the default Ethernet settings.
`timescale 1ns/1ps
module srpm_top (
  input  wire logic               clk_in,
  input  wire logic               rst_n_in,
  // Straps
  input  wire logic               speed_strap_in,
  output logic                    dflt_speed_100_out,
  output logic                    dflt_full_duplex_out,
  output logic                    dflt_aneg_en_out,
  output logic                    bus_32bit_out,
  // Role selection
  input  wire srpm_pkg::srpm_role_t data_role_in,
  input  wire srpm_pkg::srpm_role_t clock_role_in,
  input  wire logic               general_output_a_in,
  input  wire logic               general_output_b_in,
  // Internal MII monitors
  input  wire logic               mii_tx_en_in,
  input  wire logic               mii_tx_clk_in,
  input  wire logic               mii_rx_dv_in,
  input  wire logic               mii_rx_clk_in,
  // ROM controller side
  input  wire logic               rom_cs_req_in,
  input  wire logic               rom_clk_req_in,
  input  wire logic               rom_do_in,
  input  wire logic               rom_do_en_in,
  output logic                    rom_di_out,
  // ROM pins
  input  wire logic               rom_data_pin_in,
  output logic                    rom_data_pin_out,
  output logic                    rom_data_pin_oe_out,
  output logic                    rom_clock_pin_out,
  output logic                    rom_chip_select_out,
  // Twisted pair
  input  wire logic               xover_detect_in,
  input  wire logic               xover_manual_in,
  input  wire logic               tx_pos_in,
  input  wire logic               tx_neg_in,
  input  wire logic               pair_out_pos_in,
  input  wire logic               pair_out_neg_in,
  input  wire logic               pair_in_pos_in,
  input  wire logic               pair_in_neg_in,
  output logic                    pair_out_pos_out,
  output logic                    pair_out_neg_out,
  output logic                    pair_out_oe_out,
  output logic                    pair_in_pos_out,
  output logic                    pair_in_neg_out,
  output logic                    pair_in_oe_out,
  output logic                    rx_pos_out,
  output logic                    rx_neg_out
);

  typedef struct packed {
    logic in_reset;
    logic speed_strap;
    logic width_strap;
    logic speed_100;
    logic aneg_en;
    logic full_duplex;
    logic bus_32;
    logic data_pin;
    logic data_oe;
    logic clock_pin;
    logic chip_sel;
    logic rom_di;
    logic swap;
  } srpm_state_t;

  srpm_state_t st_r;
  srpm_state_t st_nxt;

  logic speed_sync;
  logic data_sync;

  // Role decode shared by the read-back gate and the chip select
  function automatic logic srpm_is_rom(input srpm_pkg::srpm_role_t role);
    return role == srpm_pkg::SRPM_ROLE_ROM;
  endfunction : srpm_is_rom

  // ********************************************************************
  // Input synchronisers
  // ********************************************************************
  // The data pin is filtered too, so the width strap sees a settled level
  srpm_sync u_speed_sync (
    .clk_in    (clk_in),
    .rst_n_in  (rst_n_in),
    .pin_in    (speed_strap_in),
    .level_out (speed_sync)
  );

  srpm_sync u_data_sync (
    .clk_in    (clk_in),
    .rst_n_in  (rst_n_in),
    .pin_in    (rom_data_pin_in),
    .level_out (data_sync)
  );

  // ********************************************************************
  // Next state
  // ********************************************************************
  always_comb begin
    st_nxt          = st_r;
    st_nxt.in_reset = 1'h0;
    // Straps are captured only on the first cycle out of reset
    if (st_r.in_reset) begin
      st_nxt.speed_strap = speed_sync;
      st_nxt.width_strap = data_sync;
    end

    if (st_nxt.speed_strap) begin
      st_nxt.speed_100 = srpm_pkg::SRPM_SPEED_100;
      st_nxt.aneg_en   = srpm_pkg::SRPM_ANEG_ON;
    end else begin
      st_nxt.speed_100 = srpm_pkg::SRPM_SPEED_10;
      st_nxt.aneg_en   = srpm_pkg::SRPM_ANEG_OFF;
    end
    st_nxt.full_duplex = srpm_pkg::SRPM_DUPLEX_HALF;
    st_nxt.bus_32 = st_nxt.width_strap ? srpm_pkg::SRPM_WIDTH_32 : srpm_pkg::SRPM_WIDTH_16;

    // Data pin role; the pin stays tristated until the strap is taken
    st_nxt.data_oe = 1'h1;
    case (data_role_in)
      srpm_pkg::SRPM_ROLE_ROM: begin
        st_nxt.data_pin = rom_do_in;
        st_nxt.data_oe  = rom_do_en_in;
      end
      srpm_pkg::SRPM_ROLE_GPO: begin
        st_nxt.data_pin = general_output_a_in;
      end
      srpm_pkg::SRPM_ROLE_MON_EN: begin
        st_nxt.data_pin = mii_tx_en_in;
      end
      default: begin
        st_nxt.data_pin = mii_tx_clk_in;
      end
    endcase
    if (st_r.in_reset) begin
      st_nxt.data_oe = 1'h0;
    end

    // ROM read data only listens in ROM role, never as a general input
    st_nxt.rom_di = srpm_is_rom(data_role_in) ? data_sync : 1'h0;

    case (clock_role_in)
      srpm_pkg::SRPM_ROLE_ROM: begin
        st_nxt.clock_pin = rom_clk_req_in;
      end
      srpm_pkg::SRPM_ROLE_GPO: begin
        st_nxt.clock_pin = general_output_b_in;
      end
      srpm_pkg::SRPM_ROLE_MON_EN: begin
        st_nxt.clock_pin = mii_rx_dv_in;
      end
      default: begin
        st_nxt.clock_pin = mii_rx_clk_in;
      end
    endcase

    st_nxt.chip_sel = rom_cs_req_in
                      && srpm_is_rom(data_role_in)
                      && srpm_is_rom(clock_role_in);

    st_nxt.swap = xover_detect_in || xover_manual_in;
  end

  // ********************************************************************
  // State register
  // ********************************************************************
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      st_r             <= '0;
      st_r.in_reset    <= 1'h1;
      st_r.speed_strap <= srpm_pkg::SRPM_RST_SPEED_STRAP;
      st_r.width_strap <= srpm_pkg::SRPM_RST_WIDTH_STRAP;
      st_r.speed_100   <= srpm_pkg::SRPM_SPEED_100;
      st_r.aneg_en     <= srpm_pkg::SRPM_ANEG_ON;
      st_r.chip_sel    <= srpm_pkg::SRPM_RST_CS;
      st_r.data_pin    <= srpm_pkg::SRPM_RST_PIN;
    end else begin
      st_r <= st_nxt;
    end
  end

  // ********************************************************************
  // Pair swap
  // ********************************************************************
  // Swap select is registered; the pair paths themselves are analog-side wiring
  srpm_pair_swap u_pair_swap (
    .swap_in     (st_r.swap),
    .tx_pos_in   (tx_pos_in),
    .tx_neg_in   (tx_neg_in),
    .out_pos_in  (pair_out_pos_in),
    .out_neg_in  (pair_out_neg_in),
    .in_pos_in   (pair_in_pos_in),
    .in_neg_in   (pair_in_neg_in),
    .out_pos_out (pair_out_pos_out),
    .out_neg_out (pair_out_neg_out),
    .out_oe_out  (pair_out_oe_out),
    .in_pos_out  (pair_in_pos_out),
    .in_neg_out  (pair_in_neg_out),
    .in_oe_out   (pair_in_oe_out),
    .rx_pos_out  (rx_pos_out),
    .rx_neg_out  (rx_neg_out)
  );

  // ********************************************************************
  // Outputs
  // ********************************************************************
  assign dflt_speed_100_out   = st_r.speed_100;
  assign dflt_full_duplex_out = st_r.full_duplex;
  assign dflt_aneg_en_out     = st_r.aneg_en;
  assign bus_32bit_out        = st_r.bus_32;
  assign rom_di_out           = st_r.rom_di;
  assign rom_data_pin_out     = st_r.data_pin;
  assign rom_data_pin_oe_out  = st_r.data_oe;
  assign rom_clock_pin_out    = st_r.clock_pin;
  assign rom_chip_select_out  = st_r.chip_sel;

endmodule : srpm_top

// ===== inc/srpm_pkg.sv
// Constants and types shared by the strap and ROM pin multiplexer.
// Assumes one 25 MHz device clock and a synchronous active-low reset.
package srpm_pkg;

  // ********************************************************************
  // Pin role selections
  // ********************************************************************
  typedef enum logic [1:0] {
    SRPM_ROLE_ROM,
    SRPM_ROLE_GPO,
    SRPM_ROLE_MON_EN,
    SRPM_ROLE_MON_CLK
  } srpm_role_t;

  // ********************************************************************
  // Reset values
  // ********************************************************************
  localparam logic SRPM_RST_SPEED_STRAP = 1'h1;
  localparam logic SRPM_RST_WIDTH_STRAP = 1'h0;
  localparam logic SRPM_RST_CS          = 1'h0;
  localparam logic SRPM_RST_PIN         = 1'h0;

  // ********************************************************************
  // Default Ethernet settings
  // ********************************************************************
  localparam logic SRPM_SPEED_10        = 1'h0;
  localparam logic SRPM_SPEED_100       = 1'h1;
  localparam logic SRPM_DUPLEX_HALF     = 1'h0;
  localparam logic SRPM_ANEG_OFF        = 1'h0;
  localparam logic SRPM_ANEG_ON         = 1'h1;
  localparam logic SRPM_WIDTH_16        = 1'h0;
  localparam logic SRPM_WIDTH_32        = 1'h1;

  // Synchroniser depth for pin inputs
  localparam int   SRPM_SYNC_STAGES     = 3;

endpackage : srpm_pkg

// ===== test/srpm_chk.sv
// Concurrent checks on the ports of the strap and ROM pin multiplexer.
// Assumes one clock domain and a synchronous active-low reset.
`timescale 1ns/1ps
module srpm_chk (
  input wire logic                 clk_in,
  input wire logic                 rst_n_in,
  input wire logic                 dflt_speed_100_out,
  input wire logic                 dflt_full_duplex_out,
  input wire logic                 dflt_aneg_en_out,
  input wire logic                 bus_32bit_out,
  input wire srpm_pkg::srpm_role_t data_role_in,
  input wire srpm_pkg::srpm_role_t clock_role_in,
  input wire logic                 general_output_a_in,
  input wire logic                 general_output_b_in,
  input wire logic                 mii_tx_en_in,
  input wire logic                 mii_tx_clk_in,
  input wire logic                 mii_rx_dv_in,
  input wire logic                 mii_rx_clk_in,
  input wire logic                 rom_cs_req_in,
  input wire logic                 rom_di_out,
  input wire logic                 rom_data_pin_out,
  input wire logic                 rom_data_pin_oe_out,
  input wire logic                 rom_clock_pin_out,
  input wire logic                 rom_chip_select_out,
  input wire logic                 xover_detect_in,
  input wire logic                 xover_manual_in,
  input wire logic                 pair_out_pos_in,
  input wire logic                 pair_in_pos_in,
  input wire logic                 rx_pos_out,
  input wire logic                 pair_in_oe_out
);
  // ************************************************************
  // Settle counter and properties
  // ************************************************************
  // Strap capture and first role update land in the first edges after release
  logic [1:0] run_r;
  logic       up;
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      run_r <= 2'h0;
    end else if (run_r != 2'h3) begin
      run_r <= run_r + 2'h1;
    end
  end
  assign up = (run_r == 2'h3);
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!rst_n_in);
  sequence s_both_rom;
    data_role_in == srpm_pkg::SRPM_ROLE_ROM && clock_role_in == srpm_pkg::SRPM_ROLE_ROM;
  endsequence
  sequence s_data_is(srpm_pkg::srpm_role_t r);
    up && data_role_in == r;
  endsequence
  a_cs_refused: assert property (!(data_role_in == srpm_pkg::SRPM_ROLE_ROM && clock_role_in == srpm_pkg::SRPM_ROLE_ROM)
    |=> !rom_chip_select_out) else $error("chip select active outside ROM role");
  a_cs_follow: assert property (up ##0 s_both_rom |=> rom_chip_select_out == $past(rom_cs_req_in))
    else $error("chip select does not follow request");
  a_data_gpo: assert property (s_data_is(srpm_pkg::SRPM_ROLE_GPO)
    |=> rom_data_pin_oe_out && rom_data_pin_out == $past(general_output_a_in)) else $error("data pin output wrong");
  a_data_txen: assert property (s_data_is(srpm_pkg::SRPM_ROLE_MON_EN) |=> rom_data_pin_out == $past(mii_tx_en_in))
    else $error("data pin transmit enable monitor wrong");
  a_data_txclk: assert property (s_data_is(srpm_pkg::SRPM_ROLE_MON_CLK) |=> rom_data_pin_out == $past(mii_tx_clk_in))
    else $error("data pin transmit clock monitor wrong");
  a_clock_gpo: assert property (up && clock_role_in == srpm_pkg::SRPM_ROLE_GPO
    |=> rom_clock_pin_out == $past(general_output_b_in)) else $error("clock pin output wrong");
  a_clock_mon: assert property (up && clock_role_in[1] |=> rom_clock_pin_out ==
    $past(clock_role_in == srpm_pkg::SRPM_ROLE_MON_EN ? mii_rx_dv_in : mii_rx_clk_in))
    else $error("clock pin receive monitor wrong");
  a_di_blocked: assert property (data_role_in != srpm_pkg::SRPM_ROLE_ROM |=> !rom_di_out)
    else $error("data pin read outside ROM role");
  a_strap_hold: assert property (up |-> $stable(bus_32bit_out) && $stable(dflt_speed_100_out))
    else $error("latched strap changed");
  a_eth_default: assert property (dflt_aneg_en_out == dflt_speed_100_out && !dflt_full_duplex_out)
    else $error("default settings inconsistent");
  a_pair_swap: assert property (up |-> pair_in_oe_out == $past(xover_detect_in || xover_manual_in) && rx_pos_out ==
    ($past(xover_detect_in || xover_manual_in) ? pair_out_pos_in : pair_in_pos_in)) else $error("pair swap wrong");
endmodule : srpm_chk
bind srpm_top srpm_chk u_chk (.clk_in, .rst_n_in, .dflt_speed_100_out, .dflt_full_duplex_out, .dflt_aneg_en_out,
  .bus_32bit_out, .data_role_in, .clock_role_in, .general_output_a_in, .general_output_b_in, .mii_tx_en_in,
  .mii_tx_clk_in, .mii_rx_dv_in, .mii_rx_clk_in, .rom_cs_req_in, .rom_di_out, .rom_data_pin_out,
  .rom_data_pin_oe_out, .rom_clock_pin_out, .rom_chip_select_out, .xover_detect_in, .xover_manual_in,
  .pair_out_pos_in, .pair_in_pos_in, .rx_pos_out, .pair_in_oe_out);

// ===== test/srpm_strap_rom_model.sv
// Board model: strap pull resistor on the ROM data pin and a serial ROM.
// Assumes the ROM answers whenever selected and the device has released the pin.
`timescale 1ns/1ps
module srpm_strap_rom_model (
  input  wire logic width_pull_in,
  input  wire logic dut_data_in,
  input  wire logic dut_oe_in,
  input  wire logic cs_in,
  output logic      data_pin_out
);
  // ************************************************************
  // Pin resolution
  // ************************************************************
  // ROM answers with the inverse of the pull so a read can never pass by luck
  assign data_pin_out = dut_oe_in ? dut_data_in
                      : cs_in ? ~width_pull_in
                      : width_pull_in;
endmodule : srpm_strap_rom_model

// ===== test/tb_strap_and_rom_pin_mux.sv
// Self-checking bench for the strap and ROM pin multiplexer.
// Assumes the board model drives the ROM data pin; inputs change on falling edges.
`timescale 1ns/1ps
module tb_strap_and_rom_pin_mux;
  // ************************************************************
  // Signals, model and design
  // ************************************************************
  logic clk_in, rst_n_in, speed_strap_in, wpull, dflt_speed_100_out, dflt_full_duplex_out, dflt_aneg_en_out;
  logic bus_32bit_out, general_output_a_in, general_output_b_in, mii_tx_en_in, mii_tx_clk_in, mii_rx_dv_in;
  logic mii_rx_clk_in, rom_cs_req_in, rom_clk_req_in, rom_do_in, rom_do_en_in, rom_di_out, rom_data_pin_in;
  logic rom_data_pin_out, rom_data_pin_oe_out, rom_clock_pin_out, rom_chip_select_out, xover_detect_in;
  logic xover_manual_in, tx_pos_in, tx_neg_in, pair_out_pos_in, pair_out_neg_in, pair_in_pos_in, pair_in_neg_in;
  logic pair_out_pos_out, pair_out_neg_out, pair_out_oe_out, pair_in_pos_out, pair_in_neg_out, pair_in_oe_out;
  logic rx_pos_out, rx_neg_out;
  srpm_pkg::srpm_role_t data_role_in, clock_role_in;
  int n_fail, num_checks;
  srpm_strap_rom_model rom (.width_pull_in(wpull), .dut_data_in(rom_data_pin_out), .dut_oe_in(rom_data_pin_oe_out),
    .cs_in(rom_chip_select_out), .data_pin_out(rom_data_pin_in));
  srpm_top dut (.clk_in, .rst_n_in, .speed_strap_in, .dflt_speed_100_out, .dflt_full_duplex_out, .dflt_aneg_en_out,
    .bus_32bit_out, .data_role_in, .clock_role_in, .general_output_a_in, .general_output_b_in, .mii_tx_en_in,
    .mii_tx_clk_in, .mii_rx_dv_in, .mii_rx_clk_in, .rom_cs_req_in, .rom_clk_req_in, .rom_do_in, .rom_do_en_in,
    .rom_di_out, .rom_data_pin_in, .rom_data_pin_out, .rom_data_pin_oe_out, .rom_clock_pin_out,
    .rom_chip_select_out, .xover_detect_in, .xover_manual_in, .tx_pos_in, .tx_neg_in, .pair_out_pos_in,
    .pair_out_neg_in, .pair_in_pos_in, .pair_in_neg_in, .pair_out_pos_out, .pair_out_neg_out, .pair_out_oe_out,
    .pair_in_pos_out, .pair_in_neg_out, .pair_in_oe_out, .rx_pos_out, .rx_neg_out);
  initial begin
    clk_in = 1'h0;
    forever #20 clk_in = ~clk_in;
  end
  task automatic tick(input int n);
    repeat (n) @(negedge clk_in);
  endtask : tick
  task automatic chk(input logic got, input logic exp);
    num_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic stop_test();
    if (n_fail == 0 && num_checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : stop_test
  // Mid-run reset with new straps, then strap pins flipped to prove they are ignored
  task automatic t_straps(input logic spd, input logic wid);
    rst_n_in = 1'h0;
    speed_strap_in = spd;
    wpull = wid;
    tick(6);
    rst_n_in = 1'h1;
    tick(3);
    speed_strap_in = ~spd;
    wpull = ~wid;
    tick(8);
    chk(dflt_speed_100_out, spd);
    chk(dflt_aneg_en_out, spd);
    chk(dflt_full_duplex_out, 1'h0);
    chk(bus_32bit_out, wid);
  endtask : t_straps
  // Every role pair but ROM/ROM, chip select requested all along
  task automatic t_pins();
    logic a;
    logic b;
    srpm_pkg::srpm_role_t dr;
    srpm_pkg::srpm_role_t cr;
    rom_cs_req_in = 1'h1;
    for (int i = 4; i < 64; i++) begin
      dr = srpm_pkg::srpm_role_t'(i[5:4]);
      cr = srpm_pkg::srpm_role_t'(i[3:2]);
      a = i[1];
      b = i[0];
      data_role_in = dr;
      clock_role_in = cr;
      general_output_a_in = a;
      mii_tx_en_in = ~a;
      mii_tx_clk_in = b;
      general_output_b_in = b;
      mii_rx_dv_in = ~b;
      mii_rx_clk_in = a;
      tick(2);
      chk(rom_chip_select_out, 1'h0);
      if (dr != srpm_pkg::SRPM_ROLE_ROM) begin
        chk(rom_data_pin_out, dr == srpm_pkg::SRPM_ROLE_GPO ? a : dr == srpm_pkg::SRPM_ROLE_MON_EN ? ~a : b);
        chk(rom_data_pin_oe_out, 1'h1);
        chk(rom_di_out, 1'h0);
      end
      if (cr != srpm_pkg::SRPM_ROLE_ROM) begin
        chk(rom_clock_pin_out, cr == srpm_pkg::SRPM_ROLE_GPO ? b : cr == srpm_pkg::SRPM_ROLE_MON_EN ? ~b : a);
      end
    end
  endtask : t_pins
  // Write bit out, then release the pin and read the ROM answer back
  task automatic t_rom();
    data_role_in = srpm_pkg::SRPM_ROLE_ROM;
    clock_role_in = srpm_pkg::SRPM_ROLE_ROM;
    rom_clk_req_in = 1'h1;
    rom_do_in = wpull;
    rom_do_en_in = 1'h1;
    tick(2);
    chk(rom_chip_select_out, 1'h1);
    chk(rom_clock_pin_out, 1'h1);
    chk(rom_data_pin_out, wpull);
    chk(rom_data_pin_oe_out, 1'h1);
    rom_clk_req_in = 1'h0;
    rom_do_en_in = 1'h0;
    tick(6);
    chk(rom_data_pin_oe_out, 1'h0);
    chk(rom_clock_pin_out, 1'h0);
    chk(rom_di_out, ~wpull);
    chk(rom_chip_select_out, 1'h1);
  endtask : t_rom
  task automatic t_swap();
    logic sw;
    pair_out_pos_in = 1'h1;
    pair_in_neg_in = 1'h1;
    for (int k = 0; k < 4; k++) begin
      {xover_detect_in, xover_manual_in} = k[1:0];
      tx_neg_in = ~k[0];
      tx_pos_in = k[0];
      sw = (k != 0);
      tick(2);
      chk(rx_pos_out, sw);
      chk(rx_neg_out, ~sw);
      chk(pair_in_oe_out, sw);
      chk(pair_out_oe_out, ~sw);
      chk(sw ? pair_in_neg_out : pair_out_neg_out, ~k[0]);
      chk(sw ? pair_in_pos_out : pair_out_pos_out, k[0]);
      chk(sw ? pair_out_pos_out : pair_in_pos_out, 1'h0);
    end
  endtask : t_swap
  initial begin
    n_fail = 0;
    num_checks = 0;
    {rst_n_in, general_output_a_in, general_output_b_in, mii_tx_en_in, mii_tx_clk_in, mii_rx_dv_in, mii_rx_clk_in,
     rom_cs_req_in, rom_clk_req_in, rom_do_in, rom_do_en_in, xover_detect_in, xover_manual_in, tx_pos_in, tx_neg_in,
     pair_out_pos_in, pair_out_neg_in, pair_in_pos_in, pair_in_neg_in} = '0;
    speed_strap_in = 1'h1;
    wpull = 1'h1;
    data_role_in = srpm_pkg::SRPM_ROLE_ROM;
    clock_role_in = srpm_pkg::SRPM_ROLE_ROM;
    tick(3);
    rst_n_in = 1'h1;
    tick(2);
    t_straps(1'h0, 1'h0);
    t_straps(1'h0, 1'h1);
    t_straps(1'h1, 1'h0);
    t_straps(1'h1, 1'h1);
    t_pins();
    t_rom();
    t_swap();
    stop_test();
  end
endmodule : tb_strap_and_rom_pin_mux
